// ==== core/pmc_power_mode_controller.sv ====
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pmc_regs.svh"

module pmc_power_mode_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic anyIrq,
    input wire logic portIrq,
    input wire logic sleepTimerIrq,
    input wire logic crystalStableIn,
    input wire logic rcStableIn,
    input wire logic [7:0] padDirIn,
    input wire logic [7:0] padOutIn,
    output logic cpuClockEnable,
    output logic regulatorOn,
    output logic crystalOscOn,
    output logic fastRcOscOn,
    output logic lowSpeedOscOn,
    output logic lowSpeedIsCrystal,
    output logic sysclkFromCrystal,
    output logic wakeIrqBlocked,
    output logic padHold,
    output logic [7:0] padDirOut,
    output logic [7:0] padOutOut,
    output logic usbEnable,
    output logic usbReset,
    output pmc_pkg::pmc_mode_t currentMode
);
    import pmc_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] syncA, syncB, syncC;
    logic portIrqS, timerIrqS, anyIrqS, xoscStbS, rcStbS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {syncA, syncB, syncC} <= 15'h0000;
        end else begin
            syncA <= {rcStableIn, crystalStableIn, anyIrq, sleepTimerIrq,
                      portIrq};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // A change counts only when the second and third stages agree.
    logic [4:0] filt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt <= 5'h00;
        end else begin
            filt <= (syncB & syncC) | (filt & (syncB | syncC));
        end
    end
    assign {rcStbS, xoscStbS, anyIrqS, timerIrqS, portIrqS} = filt;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [7:0] awAddr;
    logic awHeld, wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite, idleRequest, usbEn, wake;
    logic [1:0] mode, clock_control_reg, enteredMode;
    pmc_state_e state;
    logic [$clog2(`PMC_SEQ_CYCLES + 1) - 1:0] seqCount;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {awHeld, wHeld} <= 2'h0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr == `PMC_ADDR_POWER_CONTROL ||
                                awAddr == `PMC_ADDR_SLEEP_CONTROL ||
                                awAddr == `PMC_ADDR_CLOCK_CONTROL ||
                                awAddr == `PMC_ADDR_STATUS) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
        end
    end

    function automatic logic wrHit(input logic [7:0] a);
        return doWrite && awAddr == a && wStrb[0];
    endfunction

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // wake clears field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= `PMC_MODE_RESET;
        end else if (wake || (state == PMC_IDLE && idleRequest)) begin
            mode <= `PMC_MODE_RESET;
        end else if (wrHit(`PMC_ADDR_SLEEP_CONTROL)) begin
            mode <= wData[`PMC_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            usbEn <= 1'b0;
        end else if (state == PMC_SLEEP && enteredMode[1]) begin
            usbEn <= 1'b0;
        end else if (wrHit(`PMC_ADDR_SLEEP_CONTROL)) begin
            usbEn <= wData[`PMC_USB_EN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_control_reg <= `PMC_CLOCK_CONTROL_REG_RESET;
        end else if (wrHit(`PMC_ADDR_CLOCK_CONTROL)) begin
            clock_control_reg <= wData[1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleRequest <= 1'b0;
        end else if (wrHit(`PMC_ADDR_POWER_CONTROL) &&
                     wData[`PMC_ENTER_SLEEP_BIT] && state == PMC_ACTIVE) begin
            idleRequest <= 1'b1;
        end else if (state != PMC_ACTIVE) begin
            idleRequest <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------------
    // any interrupt wakes mode 0
    always_comb begin
        if (enteredMode == 2'h0) begin
            wake = anyIrqS;
        end else if (enteredMode == 2'h3) begin
            wake = portIrqS;
        end else begin
            wake = portIrqS || timerIrqS;
        end
        if (mode != 2'h0 && state != PMC_ACTIVE && state != PMC_IDLE) begin
            wake = 1'b0;
        end
        if (state == PMC_ACTIVE || state == PMC_UP || state == PMC_CLKSW) begin
            wake = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PMC_ACTIVE;
            enteredMode <= 2'h0;
            seqCount <= '0;
        end else begin
            unique case (state)
                PMC_ACTIVE: begin
                    if (idleRequest) begin
                        enteredMode <= mode;
                        state <= PMC_IDLE;
                        seqCount <= '0;
                    end
                end
                PMC_IDLE: state <= (|enteredMode) ? PMC_DOWN : PMC_SLEEP;
                PMC_DOWN: begin
                    seqCount <= seqCount + 1'b1;
                    if (portIrqS || (timerIrqS && enteredMode != 2'h3)) begin
                        state <= PMC_UP;
                        seqCount <= '0;
                    end else if (seqCount == `PMC_SEQ_CYCLES - 1) begin
                        state <= PMC_SLEEP;
                    end
                end
                PMC_SLEEP: begin
                    if (wake) begin
                        state <= (enteredMode == 2'h0) ? PMC_ACTIVE : PMC_UP;
                        seqCount <= '0;
                    end
                end
                PMC_UP: begin
                    seqCount <= seqCount + 1'b1;
                    if (seqCount == `PMC_SEQ_CYCLES - 1) begin
                        state <= PMC_CLKSW;
                    end
                end
                PMC_CLKSW: begin
                    if (clock_control_reg[`PMC_SYSCLK_SEL_BIT] || xoscStbS) begin
                        state <= PMC_ACTIVE;
                        enteredMode <= 2'h0;
                    end
                end
                default: state <= PMC_ACTIVE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power and clock outputs
    // ------------------------------------------------------------------
    logic deep;
    assign deep = (state == PMC_SLEEP || state == PMC_DOWN) &&
                  enteredMode != 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuClockEnable <= 1'b1;
            regulatorOn <= 1'b1;
            crystalOscOn <= 1'b1;
            fastRcOscOn <= 1'b1;
            lowSpeedOscOn <= 1'b1;
            lowSpeedIsCrystal <= 1'b0;
            sysclkFromCrystal <= 1'b0;
            wakeIrqBlocked <= 1'b0;
            usbEnable <= 1'b0;
            usbReset <= 1'b1;
            currentMode <= 2'h0;
        end else begin
            // gate CPU clock while not active
            cpuClockEnable <= (state == PMC_ACTIVE);
            regulatorOn <= !(state == PMC_SLEEP && enteredMode[1]);
            crystalOscOn <= !deep && !clock_control_reg[`PMC_SYSCLK_SEL_BIT];
            fastRcOscOn <= !deep;
            lowSpeedOscOn <= !(state == PMC_SLEEP && enteredMode == 2'h3);
            lowSpeedIsCrystal <= !clock_control_reg[`PMC_LOW_SPEED_SEL_BIT];
            sysclkFromCrystal <= !clock_control_reg[`PMC_SYSCLK_SEL_BIT] &&
                                 state == PMC_ACTIVE && xoscStbS;
            wakeIrqBlocked <= (mode != 2'h0);
            usbEnable <= usbEn && !(state == PMC_SLEEP && enteredMode[1]);
            usbReset <= !usbEn;
            currentMode <= (state == PMC_SLEEP) ? enteredMode : 2'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            padHold <= 1'b0;
            padDirOut <= 8'h00;
            padOutOut <= 8'h00;
        end else begin
            padHold <= (state != PMC_ACTIVE) && enteredMode != 2'h0;
            if (state == PMC_ACTIVE) begin
                padDirOut <= padDirIn;
                padOutOut <= padOutIn;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // reset restarts in active through rst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr)
                    `PMC_ADDR_POWER_CONTROL: s_axi_rdata <= 32'h0000_0000;
                    `PMC_ADDR_SLEEP_CONTROL: s_axi_rdata <=
                        {24'h00_0000, usbEn, xoscStbS, rcStbS, 3'h0, mode};
                    `PMC_ADDR_CLOCK_CONTROL: s_axi_rdata <=
                        {30'h0000_0000, clock_control_reg};
                    `PMC_ADDR_STATUS: s_axi_rdata <=
                        {26'h000_0000, state == PMC_SLEEP ? enteredMode : 2'h0,
                         2'h0, rcStbS, xoscStbS};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== core/pmc_regs.svh ====
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define PMC_ADDR_POWER_CONTROL 8'h00
`define PMC_ADDR_SLEEP_CONTROL 8'h04
`define PMC_ADDR_CLOCK_CONTROL 8'h08
`define PMC_ADDR_STATUS 8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMC_ENTER_SLEEP_BIT 0
`define PMC_MODE_LSB 0
`define PMC_USB_EN_BIT 7
`define PMC_SYSCLK_SEL_BIT 0
`define PMC_LOW_SPEED_SEL_BIT 1
`define PMC_ST_CRYSTAL_OSCILLATOR_STABLE_BIT 0
`define PMC_ST_RC_STABLE_BIT 1
`define PMC_ST_MODE_LSB 4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define PMC_MODE_RESET 2'h0
`define PMC_CLOCK_CONTROL_REG_RESET 2'h3
`define PMC_SEQ_TIME_NS 100
`define PMC_CLK_PERIOD_NS 10
`define PMC_SEQ_CYCLES (`PMC_SEQ_TIME_NS / `PMC_CLK_PERIOD_NS)

`endif

// ==== core/pmc_pkg.sv ====
package pmc_pkg;
    typedef logic [1:0] pmc_mode_t;

    // Gray coded along idle -> power down -> asleep -> wake up.
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'h0,
        PMC_IDLE = 3'h1,
        PMC_DOWN = 3'h3,
        PMC_SLEEP = 3'h2,
        PMC_UP = 3'h6,
        PMC_CLKSW = 3'h7
    } pmc_state_e;
endpackage

// ==== tb/pmc_checker_props.sv ====
`timescale 1ns/1ns
module pmc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpuClockEnable,
    input wire logic regulatorOn,
    input wire logic crystalOscOn,
    input wire logic fastRcOscOn,
    input wire logic lowSpeedOscOn,
    input wire logic sysclkFromCrystal,
    input wire logic wakeIrqBlocked,
    input wire logic padHold,
    input wire logic [7:0] padDirOut,
    input wire logic [7:0] padOutOut,
    input wire logic usbEnable,
    input wire logic usbReset,
    input wire pmc_pkg::pmc_mode_t currentMode
);
    import pmc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Power state relations
    // ------------------------------------------------------------
    active_run_a: assert property (cpuClockEnable |-> regulatorOn
        && lowSpeedOscOn && (crystalOscOn || fastRcOscOn))
        else $error("running without supply or clocks");
    reg_off_a: assert property (!regulatorOn |->
        !crystalOscOn && !fastRcOscOn && !cpuClockEnable)
        else $error("fast clocks alive with regulator off");
    ls_off_a: assert property (!lowSpeedOscOn |->
        !regulatorOn && currentMode == 2'h3)
        else $error("slow clock off outside deepest mode");
    pad_hold_a: assert property (padHold && $past(padHold) |->
        $stable(padDirOut) && $stable(padOutOut))
        else $error("pads moved while held");
    xtal_sys_a: assert property (sysclkFromCrystal |-> crystalOscOn)
        else $error("system clock on stopped crystal");
    sel_blocked_a: assert property (wakeIrqBlocked |-> regulatorOn)
        else $error("mode field set while asleep");
    usb_reset_a: assert property ($fell(usbEnable) |-> ##[0:2] usbReset)
        else $error("usb not reset on disable");
    // Handshake answers must stand and arrive in bounded time.
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    wr_resp_a: assert property ($rose(s_axi_awvalid) |-> ##[1:6] s_axi_bvalid)
        else $error("write not answered");
    rd_resp_a: assert property ($rose(s_axi_arvalid) |-> ##[1:6] s_axi_rvalid)
        else $error("read not answered");
    cover property (currentMode == 2'h3 && !lowSpeedOscOn);
    cover property ($rose(cpuClockEnable));
    cover property (padHold && !regulatorOn);
endmodule

bind pmc_power_mode_controller pmc_checker chk (.clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpuClockEnable(cpuClockEnable),
    .regulatorOn(regulatorOn), .crystalOscOn(crystalOscOn),
    .fastRcOscOn(fastRcOscOn), .lowSpeedOscOn(lowSpeedOscOn),
    .sysclkFromCrystal(sysclkFromCrystal), .wakeIrqBlocked(wakeIrqBlocked),
    .padHold(padHold), .padDirOut(padDirOut), .padOutOut(padOutOut),
    .usbEnable(usbEnable), .usbReset(usbReset), .currentMode(currentMode));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import pmc_pkg::*;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic anyIrq, portIrq, sleepTimerIrq, crystalStableIn, rcStableIn;
    logic cpuClockEnable, regulatorOn, crystalOscOn, fastRcOscOn;
    logic lowSpeedOscOn, lowSpeedIsCrystal, sysclkFromCrystal;
    logic wakeIrqBlocked, padHold, usbEnable, usbReset;
    logic [7:0] awaddr, araddr, padDirIn, padOutIn, padDirOut, padOutOut;
    logic [31:0] wdata, rdata, readData;
    logic [1:0] rresp, readResp, bresp, writeResp;
    pmc_mode_t currentMode;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    pmc_power_mode_controller DUT (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .anyIrq(anyIrq), .portIrq(portIrq),
        .sleepTimerIrq(sleepTimerIrq), .crystalStableIn(crystalStableIn),
        .rcStableIn(rcStableIn), .padDirIn(padDirIn), .padOutIn(padOutIn),
        .cpuClockEnable(cpuClockEnable), .regulatorOn(regulatorOn),
        .crystalOscOn(crystalOscOn), .fastRcOscOn(fastRcOscOn),
        .lowSpeedOscOn(lowSpeedOscOn), .lowSpeedIsCrystal(lowSpeedIsCrystal),
        .sysclkFromCrystal(sysclkFromCrystal),
        .wakeIrqBlocked(wakeIrqBlocked), .padHold(padHold),
        .padDirOut(padDirOut), .padOutOut(padOutOut),
        .usbEnable(usbEnable), .usbReset(usbReset),
        .currentMode(currentMode));

    // ------------------------------------------------------------
    // Bus and checking helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        writeResp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        readData = rdata;
        readResp = rresp;
        rready <= 1'b0;
    endtask

    // Asleep is judged only after the power down time has surely run.
    task automatic enter(input logic [1:0] m);
        // wake sources stay quiet until idle.
        wr(8'h04, 32'h80 | m);
        @(posedge clk);
        check(wakeIrqBlocked, 1'b1);
        // idle follows the select at once.
        wr(8'h00, 32'h1);
        while (currentMode !== m) @(posedge clk);
        repeat (12) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        check({regulatorOn, cpuClockEnable, lowSpeedIsCrystal}, 3'h6);
        rd(8'h08);
        check(readData[1:0], 2'h3);
        rd(8'h00);
        check(readData, 32'h0);
        rd(8'h10);
        check(readResp, 2'h2);
        check(readData, 32'h0);
        wr(8'h10, 32'h0);
        check(writeResp, 2'h2);
        rd(8'h0C);
        check(readData, 32'h3);
        $display("register test done");
    endtask

    task automatic t_idle;
        wr(8'h00, 32'h1);
        repeat (3) @(posedge clk);
        check({cpuClockEnable, regulatorOn, fastRcOscOn}, 3'h3);
        anyIrq <= 1'b1;
        while (cpuClockEnable !== 1'b1) @(posedge clk);
        anyIrq <= 1'b0;
        rd(8'h00);
        check(readData, 32'h0);
        $display("idle test done");
    endtask

    task automatic t_sleep(input logic [1:0] m);
        enter(m);
        padDirIn <= 8'h5A;
        padOutIn <= 8'hA5;
        repeat (3) @(posedge clk);
        check({padHold, padDirOut, padOutOut}, 17'h1C33C);
        check(regulatorOn, m == 2'h1);
        check(lowSpeedOscOn, m != 2'h3);
        check({crystalOscOn, fastRcOscOn, cpuClockEnable}, 3'h0);
        check({usbEnable, usbReset}, (m == 2'h1) ? 2'h2 : 2'h1);
        sleepTimerIrq <= (m != 2'h1);
        repeat (12) @(posedge clk);
        if (m == 2'h3) check(cpuClockEnable, 1'b0);
        portIrq <= (m != 2'h2);
        while (cpuClockEnable !== 1'b1) @(posedge clk);
        portIrq <= 1'b0;
        sleepTimerIrq <= 1'b0;
        padDirIn <= 8'hC3;
        padOutIn <= 8'h3C;
        check(wakeIrqBlocked, 1'b0);
        rd(8'h04);
        check(readData[1:0], 2'h0);
        check(readData[7], m == 2'h1);
        rd(8'h08);
        check(readData[1:0], 2'h3);
        $display("sleep test done, mode %0d", m);
    endtask

    task automatic t_abort;
        logic slept;
        slept = 1'b0;
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        portIrq <= 1'b1;
        repeat (30) begin
            @(posedge clk);
            slept = slept | (regulatorOn === 1'b0);
        end
        portIrq <= 1'b0;
        check(slept, 1'b0);
        check({cpuClockEnable, regulatorOn}, 2'h3);
        rd(8'h04);
        check(readData[1:0], 2'h0);
        wr(8'h04, 32'h0);
        $display("abort test done");
    endtask

    task automatic t_crystal;
        // slow clock on crystal, so no RC gap applies.
        wr(8'h08, 32'h0);
        repeat (8) @(posedge clk);
        check({sysclkFromCrystal, lowSpeedIsCrystal}, 2'h3);
        enter(2'h1);
        crystalStableIn <= 1'b0;
        portIrq <= 1'b1;
        repeat (30) @(posedge clk);
        portIrq <= 1'b0;
        check({crystalOscOn, fastRcOscOn, sysclkFromCrystal}, 3'h6);
        crystalStableIn <= 1'b1;
        repeat (8) @(posedge clk);
        check({sysclkFromCrystal, cpuClockEnable}, 2'h3);
        wr(8'h08, 32'h3);
        $display("crystal test done");
    endtask

    task automatic t_reset_sleep;
        enter(2'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check({cpuClockEnable, regulatorOn}, 2'h3);
        rd(8'h04);
        check(readData[1:0], 2'h0);
        $display("reset test done");
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test;
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {anyIrq, portIrq, sleepTimerIrq} = 3'h0;
        {crystalStableIn, rcStableIn} = 2'h3;
        {awaddr, araddr, wdata} = 48'h0;
        padDirIn = 8'hC3;
        padOutIn = 8'h3C;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_idle;
        for (int m = 1; m < 4; m++) t_sleep(2'(m));
        t_abort;
        t_crystal;
        t_reset_sleep;
        stop_test;
    end
endmodule
